// [bench/tb.sv]
/*
   self-checking bench for icf_top: register table, context events, summaries, interrupt.
   assumes read data one cycle after the read strobe and registered output levels.
*/
`timescale 1ns/1ps
module tb
   import icf_pkg::*;
;
   typedef struct {
      logic we;
      logic [ICF_ADDR_W-1:0] wa;
      logic [ICF_DATA_W-1:0] wd;
      logic [ICF_ADDR_W-1:0] ra;
      logic [ICF_DATA_W-1:0] ex;
   } icf_row_t;
   logic i_clk_sys, i_reset, i_wr, i_rd;
   logic [ICF_ADDR_W-1:0] i_addr;
   logic [ICF_DATA_W-1:0] i_wdata, o_rdata;
   logic [ICF_CTX_N-1:0] i_tx_last_done, i_tx_irq_bits, i_rx_input_done, i_rx_irq_bits;
   logic [ICF_MAIN_N-1:0] i_main_event_bits;
   logic o_iso_transmit_summary, o_iso_receive_summary, o_irq;
   logic [7:0] o_async_priority_budget;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [ICF_ADDR_W-1:0] rst_addr [6] = '{8'h90, 8'ha0, 8'h98, 8'ha8, 8'hdc, 8'h80};
   // write flag, write address, data, read address, expected read
   icf_row_t rows [15] = '{
      '{1'b1, 8'hdc, 32'hffff_ffff, 8'hdc, 32'h0000_00ff},
      '{1'b1, 8'hdc, 32'h0000_0000, 8'hdc, 32'h0000_0000},
      '{1'b1, 8'h98, 32'h0000_00a5, 8'h98, 32'h0000_00a5},
      '{1'b1, 8'h9c, 32'h0000_0021, 8'h9c, 32'h0000_0084},
      '{1'b1, 8'ha8, 32'hffff_ff0f, 8'hac, 32'h0000_000f},
      '{1'b1, 8'hac, 32'h0000_0003, 8'ha8, 32'h0000_000c},
      '{1'b1, 8'h90, 32'h0000_0101, 8'h90, 32'h0000_0001},
      '{1'b0, 8'h00, 32'h0000_0000, 8'h94, 32'h0000_0000},
      '{1'b1, 8'h90, 32'h0000_0084, 8'h94, 32'h0000_0084},
      '{1'b1, 8'h94, 32'h0000_0000, 8'h90, 32'h0000_0085},
      '{1'b1, 8'h94, 32'h0000_00ff, 8'h90, 32'h0000_0000},
      '{1'b1, 8'ha0, 32'hffff_ffff, 8'ha0, 32'h0000_00ff},
      '{1'b0, 8'h00, 32'h0000_0000, 8'ha4, 32'h0000_000c},
      '{1'b1, 8'ha4, 32'h0000_00ff, 8'ha0, 32'h0000_0000},
      '{1'b1, 8'h50, 32'hffff_ffff, 8'h50, 32'h0000_0000}};

   icf_top i_icf_top (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_wr(i_wr), .i_rd(i_rd),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_tx_last_done(i_tx_last_done),
      .i_tx_irq_bits(i_tx_irq_bits), .i_rx_input_done(i_rx_input_done),
      .i_rx_irq_bits(i_rx_irq_bits), .i_main_event_bits(i_main_event_bits),
      .o_rdata(o_rdata), .o_iso_transmit_summary(o_iso_transmit_summary),
      .o_iso_receive_summary(o_iso_receive_summary),
      .o_async_priority_budget(o_async_priority_budget), .o_irq(o_irq));

   initial begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end

   task automatic complete_run;
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         complete_run();
      end
   end

   task automatic chk(input logic [ICF_DATA_W-1:0] seen, input logic [ICF_DATA_W-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [ICF_ADDR_W-1:0] a, input logic [ICF_DATA_W-1:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rdc(input logic [ICF_ADDR_W-1:0] a, input logic [ICF_DATA_W-1:0] ex);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      @(negedge i_clk_sys);
      chk(o_rdata, ex);
   endtask : rdc

   task automatic settle(input int n);
      repeat (n) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
   endtask : settle

   task automatic hw(input logic [7:0] td, input logic [7:0] ti, input logic [7:0] rd,
         input logic [7:0] ri);
      @(posedge i_clk_sys);
      i_tx_last_done <= td;
      i_tx_irq_bits <= ti;
      i_rx_input_done <= rd;
      i_rx_irq_bits <= ri;
   endtask : hw

   initial begin
      i_reset = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 32'h0000_0000;
      i_tx_last_done = 8'h00;
      i_tx_irq_bits = 8'h00;
      i_rx_input_done = 8'h00;
      i_rx_irq_bits = 8'h00;
      i_main_event_bits = 10'h000;
      repeat (10) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      foreach (rows[k]) begin
         if (rows[k].we) begin
            wr(rows[k].wa, rows[k].wd);
         end
         rdc(rows[k].ra, rows[k].ex);
      end
      // tx context 2 held high: one event, no interrupt while global enable off
      hw(8'h04, 8'h04, 8'h00, 8'h00);
      settle(6);
      chk({31'h0, o_iso_transmit_summary}, 32'h0000_0001);
      chk({31'h0, o_irq}, 32'h0000_0000);
      rdc(ICF_TX_EV_SET, 32'h0000_0004);
      wr(ICF_TX_EV_CLR, 32'h0000_0004);
      settle(6);
      rdc(ICF_TX_EV_SET, 32'h0000_0000);
      chk({31'h0, o_iso_transmit_summary}, 32'h0000_0000);
      // tx done without interrupt bits, rx context 7 with them but disabled
      hw(8'h08, 8'h00, 8'h80, 8'h80);
      settle(6);
      rdc(ICF_TX_EV_SET, 32'h0000_0000);
      rdc(ICF_RX_EV_SET, 32'h0000_0080);
      chk({31'h0, o_iso_receive_summary}, 32'h0000_0000);
      wr(ICF_RX_EN_SET, 32'h0000_0080);
      settle(4);
      chk({31'h0, o_iso_receive_summary}, 32'h0000_0001);
      hw(8'h00, 8'h00, 8'h00, 8'h00);
      // main enables with global on
      wr(ICF_MAIN_EN_SET, 32'h8000_0080);
      settle(4);
      chk({31'h0, o_irq}, 32'h0000_0001);
      wr(ICF_MAIN_EN_CLR, 32'h0000_0080);
      settle(4);
      chk({31'h0, o_irq}, 32'h0000_0000);
      wr(ICF_MAIN_EN_SET, 32'h0000_033f);
      for (int b = 0; b < 10; b++) begin
         if (b != 6 && b != 7) begin
            @(posedge i_clk_sys);
            i_main_event_bits <= 10'h001 << b;
            settle(4);
            chk({31'h0, o_irq}, 32'h0000_0001);
         end
      end
      // main event readback: raw, masked, and the enable word with global bit
      rdc(ICF_MAIN_EV_SET, 32'h0000_0280);
      rdc(ICF_MAIN_EV_CLR, 32'h0000_0200);
      rdc(ICF_MAIN_EN_SET, 32'h8000_033f);
      // only the transmit summary enabled toward the interrupt
      wr(ICF_MAIN_EN_CLR, 32'h0000_033f);
      wr(ICF_MAIN_EN_SET, 32'h0000_0040);
      @(posedge i_clk_sys);
      i_main_event_bits <= 10'h000;
      settle(4);
      chk({31'h0, o_irq}, 32'h0000_0000);
      wr(ICF_TX_EV_SET, 32'h0000_0080);
      settle(4);
      chk({31'h0, o_iso_transmit_summary}, 32'h0000_0001);
      chk({31'h0, o_irq}, 32'h0000_0001);
      wr(ICF_MAIN_EN_CLR, 32'h8000_0000);
      settle(4);
      chk({31'h0, o_irq}, 32'h0000_0000);
      wr(ICF_BUDGET, 32'h0000_005a);
      settle(1);
      chk({24'h0, o_async_priority_budget}, 32'h0000_005a);
      // second reset returns everything to zero
      @(posedge i_clk_sys);
      i_reset <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      foreach (rst_addr[k]) begin
         rdc(rst_addr[k], 32'h0000_0000);
      end
      chk({24'h0, o_async_priority_budget}, 32'h0000_0000);
      chk({31'h0, o_irq}, 32'h0000_0000);
      complete_run();
   end
endmodule : tb

// [hw/icf_pkg.sv]
/*
   constants, register map and carrier types for the isochronous context interrupt and
   fairness register block.
   assumes one system clock, synchronous active-high reset, and a plain register port.
*/
package icf_pkg;
   localparam int unsigned ICF_ADDR_W = 8;
   localparam int unsigned ICF_DATA_W = 32;
   localparam int unsigned ICF_CTX_N = 8;
   localparam int unsigned ICF_MAIN_N = 10;
   localparam logic [ICF_ADDR_W-1:0] ICF_TX_EV_SET = 8'h90;
   localparam logic [ICF_ADDR_W-1:0] ICF_TX_EV_CLR = 8'h94;
   localparam logic [ICF_ADDR_W-1:0] ICF_TX_EN_SET = 8'h98;
   localparam logic [ICF_ADDR_W-1:0] ICF_TX_EN_CLR = 8'h9c;
   localparam logic [ICF_ADDR_W-1:0] ICF_RX_EV_SET = 8'ha0;
   localparam logic [ICF_ADDR_W-1:0] ICF_RX_EV_CLR = 8'ha4;
   localparam logic [ICF_ADDR_W-1:0] ICF_RX_EN_SET = 8'ha8;
   localparam logic [ICF_ADDR_W-1:0] ICF_RX_EN_CLR = 8'hac;
   localparam logic [ICF_ADDR_W-1:0] ICF_BUDGET = 8'hdc;
   localparam logic [ICF_ADDR_W-1:0] ICF_MAIN_EN_SET = 8'h80;
   localparam logic [ICF_ADDR_W-1:0] ICF_MAIN_EN_CLR = 8'h84;
   localparam logic [ICF_ADDR_W-1:0] ICF_MAIN_EV_SET = 8'h88;
   localparam logic [ICF_ADDR_W-1:0] ICF_MAIN_EV_CLR = 8'h8c;
   localparam int unsigned ICF_BIT_TX_SUM = 6;
   localparam int unsigned ICF_BIT_RX_SUM = 7;
   localparam int unsigned ICF_BIT_GLOBAL = 31;
   localparam logic [ICF_CTX_N-1:0] ICF_CTX_RST = 8'h00;
   localparam logic [7:0] ICF_BUDGET_RST = 8'h00;
   localparam logic [ICF_DATA_W-1:0] ICF_ZERO = 32'h0000_0000;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ICF_ADDR_W-1:0] addr;
      logic [ICF_DATA_W-1:0] wdata;
   } icf_req_t;
   typedef struct packed {
      logic set_wr;
      logic clr_wr;
      logic [ICF_CTX_N-1:0] data;
   } icf_sc_t;
endpackage : icf_pkg

// [hw/icf_read_mux.sv]
/*
   read data select for the register block.
   assumes the register values are flop outputs of the same clock.
*/
`timescale 1ns/1ps
module icf_read_mux
   import icf_pkg::*;
(
   input wire logic [ICF_ADDR_W-1:0] i_addr,
   input wire logic [ICF_CTX_N-1:0] i_tx_ev,
   input wire logic [ICF_CTX_N-1:0] i_tx_en,
   input wire logic [ICF_CTX_N-1:0] i_rx_ev,
   input wire logic [ICF_CTX_N-1:0] i_rx_en,
   input wire logic [7:0] i_budget,
   input wire logic [ICF_DATA_W-1:0] i_main_en,
   input wire logic [ICF_DATA_W-1:0] i_main_ev,
   output logic [ICF_DATA_W-1:0] o_rdata
);
   always_comb begin
      o_rdata = ICF_ZERO;
      unique case (i_addr)
         ICF_TX_EV_SET: o_rdata[ICF_CTX_N-1:0] = i_tx_ev;
         ICF_TX_EV_CLR: o_rdata[ICF_CTX_N-1:0] = i_tx_ev & i_tx_en;
         ICF_TX_EN_SET, ICF_TX_EN_CLR: o_rdata[ICF_CTX_N-1:0] = i_tx_en;
         ICF_RX_EV_SET: o_rdata[ICF_CTX_N-1:0] = i_rx_ev;
         ICF_RX_EV_CLR: o_rdata[ICF_CTX_N-1:0] = i_rx_ev & i_rx_en;
         ICF_RX_EN_SET, ICF_RX_EN_CLR: o_rdata[ICF_CTX_N-1:0] = i_rx_en;
         ICF_BUDGET: o_rdata[7:0] = i_budget;
         ICF_MAIN_EN_SET, ICF_MAIN_EN_CLR: o_rdata = i_main_en;
         ICF_MAIN_EV_SET: o_rdata = i_main_ev;
         ICF_MAIN_EV_CLR: o_rdata = i_main_ev & i_main_en;
         default: o_rdata = ICF_ZERO;
      endcase
   end
endmodule : icf_read_mux

// [hw/icf_sc_reg.sv]
/*
   set/clear register bank; hardware events set on rising edge of their request.
   assumes requests are synchronous to i_clk_sys.
*/
`timescale 1ns/1ps
module icf_sc_reg
   import icf_pkg::*;
#(
   parameter int unsigned W = 8,
   parameter logic [W-1:0] RST = '0,
   parameter bit EDGE = 1'b1
) (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_set_wr,
   input wire logic i_clr_wr,
   input wire logic [W-1:0] i_wdata,
   input wire logic [W-1:0] i_hw,
   output logic [W-1:0] o_val
);
   logic [W-1:0] hw_prev_q;
   logic [W-1:0] hw_rise;
   logic [W-1:0] val_q;
   logic [W-1:0] val_d;

   assign hw_rise = EDGE ? (i_hw & ~hw_prev_q) : '0;
   assign o_val = val_q;

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         hw_prev_q <= '0;
      end else begin
         hw_prev_q <= i_hw;
      end
   end

   always_comb begin
      val_d = val_q;
      if (i_clr_wr) begin
         val_d = val_d & ~i_wdata;
      end
      if (i_set_wr) begin
         val_d = val_d | i_wdata;
      end
      val_d = val_d | hw_rise;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         val_q <= RST;
      end else begin
         val_q <= val_d;
      end
   end

   set_wins_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      (|hw_rise) |=> ((val_q & $past(hw_rise)) == $past(hw_rise)))
      else $error("hardware event lost");
   no_hw_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      !i_clr_wr |=> ((val_q & $past(val_q)) == $past(val_q)))
      else $error("bit cleared without clear write");
endmodule : icf_sc_reg

// [hw/icf_top.sv]
/*
   isochronous context interrupt events, enables, main enable low bits and the
   asynchronous priority budget register.
   assumes context done pulses and main event bits come from logic on i_clk_sys.
*/
`timescale 1ns/1ps
module icf_top
   import icf_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [ICF_ADDR_W-1:0] i_addr,
   input wire logic [ICF_DATA_W-1:0] i_wdata,
   input wire logic [ICF_CTX_N-1:0] i_tx_last_done,
   input wire logic [ICF_CTX_N-1:0] i_tx_irq_bits,
   input wire logic [ICF_CTX_N-1:0] i_rx_input_done,
   input wire logic [ICF_CTX_N-1:0] i_rx_irq_bits,
   input wire logic [ICF_MAIN_N-1:0] i_main_event_bits,
   output logic [ICF_DATA_W-1:0] o_rdata,
   output logic o_iso_transmit_summary,
   output logic o_iso_receive_summary,
   output logic [7:0] o_async_priority_budget,
   output logic o_irq
);
   icf_req_t req;
   icf_sc_t tx_ev_w;
   icf_sc_t rx_ev_w;
   icf_sc_t tx_en_w;
   icf_sc_t rx_en_w;
   logic [ICF_CTX_N-1:0] tx_ev;
   logic [ICF_CTX_N-1:0] rx_ev;
   logic [ICF_CTX_N-1:0] tx_en;
   logic [ICF_CTX_N-1:0] rx_en;
   logic [ICF_CTX_N-1:0] tx_irq_q;
   logic [ICF_CTX_N-1:0] rx_irq_q;
   logic [ICF_MAIN_N-1:0] main_en_q;
   logic global_irq_enable_q;
   logic [7:0] budget_q;
   logic [ICF_DATA_W-1:0] main_en_word;
   logic [ICF_DATA_W-1:0] main_ev_word;
   logic [ICF_DATA_W-1:0] rdata_d;
   logic [ICF_MAIN_N-1:0] main_ev_full;
   logic tx_sum_d;
   logic rx_sum_d;
   logic irq_d;

   assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
   assign tx_ev_w = '{set_wr: req.wr && req.addr == ICF_TX_EV_SET,
      clr_wr: req.wr && req.addr == ICF_TX_EV_CLR, data: req.wdata[ICF_CTX_N-1:0]};
   assign rx_ev_w = '{set_wr: req.wr && req.addr == ICF_RX_EV_SET,
      clr_wr: req.wr && req.addr == ICF_RX_EV_CLR, data: req.wdata[ICF_CTX_N-1:0]};
   assign tx_en_w = '{set_wr: req.wr && req.addr == ICF_TX_EN_SET,
      clr_wr: req.wr && req.addr == ICF_TX_EN_CLR, data: req.wdata[ICF_CTX_N-1:0]};
   assign rx_en_w = '{set_wr: req.wr && req.addr == ICF_RX_EN_SET,
      clr_wr: req.wr && req.addr == ICF_RX_EN_CLR, data: req.wdata[ICF_CTX_N-1:0]};

   // context interrupt level: done with interrupt bits set
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         tx_irq_q <= ICF_CTX_RST;
         rx_irq_q <= ICF_CTX_RST;
      end else begin
         tx_irq_q <= i_tx_last_done & i_tx_irq_bits;
         rx_irq_q <= i_rx_input_done & i_rx_irq_bits;
      end
   end

   icf_sc_reg #(.W(ICF_CTX_N), .RST(ICF_CTX_RST), .EDGE(1'b1)) u_tx_ev (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_set_wr(tx_ev_w.set_wr),
      .i_clr_wr(tx_ev_w.clr_wr), .i_wdata(tx_ev_w.data), .i_hw(tx_irq_q), .o_val(tx_ev));
   icf_sc_reg #(.W(ICF_CTX_N), .RST(ICF_CTX_RST), .EDGE(1'b1)) u_rx_ev (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_set_wr(rx_ev_w.set_wr),
      .i_clr_wr(rx_ev_w.clr_wr), .i_wdata(rx_ev_w.data), .i_hw(rx_irq_q), .o_val(rx_ev));
   icf_sc_reg #(.W(ICF_CTX_N), .RST(ICF_CTX_RST), .EDGE(1'b0)) u_tx_en (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_set_wr(tx_en_w.set_wr),
      .i_clr_wr(tx_en_w.clr_wr), .i_wdata(tx_en_w.data), .i_hw(ICF_CTX_RST), .o_val(tx_en));
   icf_sc_reg #(.W(ICF_CTX_N), .RST(ICF_CTX_RST), .EDGE(1'b0)) u_rx_en (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_set_wr(rx_en_w.set_wr),
      .i_clr_wr(rx_en_w.clr_wr), .i_wdata(rx_en_w.data), .i_hw(ICF_CTX_RST), .o_val(rx_en));

   // main enable low bits and global enable
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         main_en_q <= '0;
         global_irq_enable_q <= 1'b0;
      end else if (req.wr && req.addr == ICF_MAIN_EN_SET) begin
         main_en_q <= main_en_q | req.wdata[ICF_MAIN_N-1:0];
         global_irq_enable_q <= global_irq_enable_q | req.wdata[ICF_BIT_GLOBAL];
      end else if (req.wr && req.addr == ICF_MAIN_EN_CLR) begin
         main_en_q <= main_en_q & ~req.wdata[ICF_MAIN_N-1:0];
         global_irq_enable_q <= global_irq_enable_q & ~req.wdata[ICF_BIT_GLOBAL];
      end
   end

   // priority budget storage
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         budget_q <= ICF_BUDGET_RST;
      end else if (req.wr && req.addr == ICF_BUDGET) begin
         budget_q <= req.wdata[7:0];
      end
   end

   assign tx_sum_d = |(tx_ev & tx_en);
   assign rx_sum_d = |(rx_ev & rx_en);

   always_comb begin
      main_ev_full = i_main_event_bits;
      main_ev_full[ICF_BIT_TX_SUM] = o_iso_transmit_summary;
      main_ev_full[ICF_BIT_RX_SUM] = o_iso_receive_summary;
   end

   always_comb begin
      main_en_word = ICF_ZERO;
      main_en_word[ICF_MAIN_N-1:0] = main_en_q;
      main_en_word[ICF_BIT_GLOBAL] = global_irq_enable_q;
      main_ev_word = ICF_ZERO;
      main_ev_word[ICF_MAIN_N-1:0] = main_ev_full;
   end

   assign irq_d = global_irq_enable_q && |(main_ev_full & main_en_q);

   icf_read_mux u_rmux (
      .i_addr(req.addr), .i_tx_ev(tx_ev), .i_tx_en(tx_en), .i_rx_ev(rx_ev),
      .i_rx_en(rx_en), .i_budget(budget_q), .i_main_en(main_en_word),
      .i_main_ev(main_ev_word), .o_rdata(rdata_d));

   // outputs from flops
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_rdata <= ICF_ZERO;
         o_iso_transmit_summary <= 1'b0;
         o_iso_receive_summary <= 1'b0;
         o_async_priority_budget <= ICF_BUDGET_RST;
         o_irq <= 1'b0;
      end else begin
         o_rdata <= req.rd ? rdata_d : ICF_ZERO;
         o_iso_transmit_summary <= tx_sum_d;
         o_iso_receive_summary <= rx_sum_d;
         o_async_priority_budget <= budget_q;
         o_irq <= irq_d;
      end
   end

   tx_summary_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      1'b1 |=> (o_iso_transmit_summary == |($past(tx_ev) & $past(tx_en))))
      else $error("transmit summary mismatch");
   rx_summary_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      1'b1 |=> (o_iso_receive_summary == |($past(rx_ev) & $past(rx_en))))
      else $error("receive summary mismatch");
   global_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      !global_irq_enable_q |=> !o_irq)
      else $error("interrupt while globally disabled");
   irq_mask_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      (main_ev_full & main_en_q) == '0 |=> !o_irq)
      else $error("interrupt with no enabled event");
   tx_done_sets_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      (|(i_tx_last_done & i_tx_irq_bits & ~tx_irq_q))
      |-> ##2 ((tx_ev & $past(i_tx_last_done & i_tx_irq_bits & ~tx_irq_q, 2))
      == $past(i_tx_last_done & i_tx_irq_bits & ~tx_irq_q, 2)))
      else $error("tx context event not raised");
   rx_done_sets_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      (|(i_rx_input_done & i_rx_irq_bits & ~rx_irq_q))
      |-> ##2 ((rx_ev & $past(i_rx_input_done & i_rx_irq_bits & ~rx_irq_q, 2))
      == $past(i_rx_input_done & i_rx_irq_bits & ~rx_irq_q, 2)))
      else $error("rx context event not raised");
   raw_read_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      (req.rd && req.addr == ICF_TX_EV_SET)
      |=> o_rdata == {24'h00_0000, $past(tx_ev)})
      else $error("raw event read wrong");
   masked_read_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      (req.rd && req.addr == ICF_RX_EV_CLR)
      |=> o_rdata == {24'h00_0000, $past(rx_ev) & $past(rx_en)})
      else $error("masked event read wrong");
   enable_read_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      (req.rd && req.addr == ICF_TX_EN_CLR)
      |=> o_rdata == {24'h00_0000, $past(tx_en)})
      else $error("enable read wrong");
   budget_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      (req.wr && req.addr == ICF_BUDGET)
      |-> ##2 o_async_priority_budget == $past(req.wdata[7:0], 2))
      else $error("budget not stored");

   tx_event_c: cover property (@(posedge i_clk_sys) disable iff (i_reset) o_iso_transmit_summary);
   rx_event_c: cover property (@(posedge i_clk_sys) disable iff (i_reset) o_iso_receive_summary);
   irq_c: cover property (@(posedge i_clk_sys) disable iff (i_reset) o_irq);
endmodule : icf_top
